// [common/h_bridge_regs.svh]
// Timing constants for the H-bridge drive control
`ifndef H_BRIDGE_REGS_SVH
`define H_BRIDGE_REGS_SVH

// ------------------------------------------------------------
// Clock and times
// ------------------------------------------------------------
`define CLOCK_HZ              10000000
`define SLEEP_DELAY_US        1000
`define SLEEP_DELAY_CYC       ((`SLEEP_DELAY_US * (`CLOCK_HZ / 1000000)))
`define WAKE_HOLD_US          5
`define WAKE_HOLD_CYC         ((`WAKE_HOLD_US * (`CLOCK_HZ / 1000000)))
`define WAKE_TIME_US          50
`define WAKE_TIME_CYC         ((`WAKE_TIME_US * (`CLOCK_HZ / 1000000)))
`define CHOP_OFF_US           25
`define CHOP_OFF_CYC          ((`CHOP_OFF_US * (`CLOCK_HZ / 1000000)))
`define GAP_NS                200
`define GAP_CYC               ((`GAP_NS * (`CLOCK_HZ / 1000000) + 999) / 1000)
`define OC_FILTER_US          3
`define OC_FILTER_CYC         ((`OC_FILTER_US * (`CLOCK_HZ / 1000000)))
`define RETRY_US              1600
`define RETRY_CYC             ((`RETRY_US * (`CLOCK_HZ / 1000000)))

`endif

// [common/h_bridge_pkg.sv]
// Types shared by the H-bridge drive control modules
package h_bridge_pkg;

   // ------------------------------------------------------------
   // Leg drive command and power state
   // ------------------------------------------------------------
   typedef enum logic [2:0]
   {
      LEG_OFF  = 3'b001,
      LEG_LOW  = 3'b010,
      LEG_HIGH = 3'b100
   } leg_cmd_t;

   typedef enum logic [3:0]
   {
      PWR_SLEEP = 4'b0001,
      PWR_WAKE  = 4'b0010,
      PWR_RUN   = 4'b0100,
      PWR_RETRY = 4'b1000
   } power_state_t;

endpackage

// [common/leg_if.sv]
// Command and gate signals of one bridge leg
`timescale 1ns/1ps
interface leg_if;
   import h_bridge_pkg::*;
   leg_cmd_t cmd;
   logic     gate_high;
   logic     gate_low;

   modport ctrl (output cmd, input gate_high, input gate_low);
   modport leg  (input cmd, output gate_high, output gate_low);
endinterface

// [rtl/input_sync.sv]
// Three-stage synchroniser; output changes when stages two and three agree
`timescale 1ns/1ps
module input_sync
(
   input  wire logic clock,
   input  wire logic rst_n,
   input  wire logic pin,
   output logic      level
);
   typedef struct packed
   {
      logic s1;
      logic s2;
      logic s3;
      logic level;
   } sync_state_t;

   sync_state_t state;
   sync_state_t next_state;

   always_comb
   begin
      next_state    = state;
      next_state.s1 = pin;
      next_state.s2 = state.s1;
      next_state.s3 = state.s2;
      if (state.s2 == state.s3)
      begin
         next_state.level = state.s3;
      end
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state <= '0;
      end
      else
      begin
         state <= next_state;
      end
   end

   assign level = state.level;
endmodule

// [rtl/leg_driver.sv]
// One bridge leg with a both-off gap on every high/low swap
`timescale 1ns/1ps
`include "h_bridge_regs.svh"
module leg_driver
(
   input  wire logic clock,
   input  wire logic rst_n,
   leg_if.leg        bus
);
   import h_bridge_pkg::*;

   typedef struct packed
   {
      logic [3:0] gap;
      logic       high;
      logic       low;
   } leg_state_t;

   leg_state_t state;
   leg_state_t next_state;

   always_comb
   begin
      next_state = state;
      if (state.gap != 4'h0)
      begin
         next_state.gap = state.gap - 4'h1;
      end
      unique case (bus.cmd)
         LEG_OFF:
         begin
            next_state.high = 1'b0;
            next_state.low  = 1'b0;
            // A short off spell between opposite sides must still give the full gap [R9]
            if (state.high || state.low)
            begin
               next_state.gap = 4'(`GAP_CYC);
            end
         end
         LEG_LOW:
         begin
            next_state.high = 1'b0;
            // Opposite side was on: hold both off first [R9]
            if (state.high)
            begin
               next_state.gap = 4'(`GAP_CYC);
               next_state.low = 1'b0;
            end
            else
            begin
               next_state.low = (state.gap <= 4'h1);
            end
         end
         LEG_HIGH:
         begin
            next_state.low = 1'b0;
            if (state.low)
            begin
               next_state.gap  = 4'(`GAP_CYC); // [R9]
               next_state.high = 1'b0;
            end
            else
            begin
               next_state.high = (state.gap <= 4'h1);
            end
         end
         default:
         begin
            next_state.high = 1'b0;
            next_state.low  = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state <= '0;
      end
      else
      begin
         state <= next_state;
      end
   end

   assign bus.gate_high = state.high;
   assign bus.gate_low  = state.low;
endmodule

// [rtl/h_bridge_drive_control.sv]
// Top of the H-bridge drive control: mode decode, sleep, chopping, faults
`timescale 1ns/1ps
`include "h_bridge_regs.svh"

// Behaviour
// R1 - Both inputs low: all transistors off, coast
// R2 - A-only forward, B-only reverse drive
// R3 - Both inputs high: low sides on, brake
// R4 - Inputs low for sleep delay: enter sleep
// R5 - Power-up with inputs low: sleep at once
// R6 - Wake after 5 us high, run 50 us later
// R7 - Current trip: both low sides for off-time
// R8 - After off-time, restore input-selected state
// R9 - Both-off gap on every leg swap
// R10 - Supply low: all off until cleared
// R11 - Filtered overcurrent: off for retry, repeat
// R12 - Over-temperature: all off until cleared
// R13 - Controller PWMs drive with brake or coast
// R14 - Faults over chopping over inputs; input restarts sleep
// R15 - Outputs off during wake time
module h_bridge_drive_control
#(
   parameter int unsigned sleep_delay_cycles = `SLEEP_DELAY_CYC,
   parameter int unsigned retry_cycles       = `RETRY_CYC
)
(
   input  wire logic clock,
   input  wire logic rst_n,
   input  wire logic ctrl_input_a,
   input  wire logic ctrl_input_b,
   input  wire logic current_trip_level,
   input  wire logic overcurrent_level,
   input  wire logic supply_low_lockout,
   input  wire logic thermal_cutoff,
   output logic      bridge_a_high,
   output logic      bridge_a_low,
   output logic      bridge_b_high,
   output logic      bridge_b_low,
   output logic      asleep
);
   import h_bridge_pkg::*;

   // ------------------------------------------------------------
   // Input synchronisers
   // ------------------------------------------------------------
   logic in_a;
   logic in_b;
   logic trip;
   logic over_i;
   logic low_v;
   logic hot;

   input_sync sync_a (.clock(clock), .rst_n(rst_n), .pin(ctrl_input_a), .level(in_a));
   input_sync sync_b (.clock(clock), .rst_n(rst_n), .pin(ctrl_input_b), .level(in_b));
   input_sync sync_t (.clock(clock), .rst_n(rst_n), .pin(current_trip_level), .level(trip));
   input_sync sync_o (.clock(clock), .rst_n(rst_n), .pin(overcurrent_level), .level(over_i));
   input_sync sync_u (.clock(clock), .rst_n(rst_n), .pin(supply_low_lockout), .level(low_v));
   input_sync sync_h (.clock(clock), .rst_n(rst_n), .pin(thermal_cutoff), .level(hot));

   // ------------------------------------------------------------
   // Control state
   // ------------------------------------------------------------
   typedef struct packed
   {
      power_state_t pwr;
      logic [15:0]  sleep_cnt;
      logic [15:0]  retry_cnt;
      logic [9:0]   wake_cnt;
      logic [9:0]   chop_cnt;
      logic [7:0]   oc_cnt;
      logic         boot;
      leg_cmd_t     cmd_a;
      leg_cmd_t     cmd_b;
   } ctrl_state_t;

   ctrl_state_t state;
   ctrl_state_t next_state;
   logic        any_in;
   logic        fault;
   leg_cmd_t    sel_a;
   leg_cmd_t    sel_b;

   leg_if leg_a ();
   leg_if leg_b ();

   assign any_in = in_a | in_b;
   assign fault  = low_v | hot; // [R10] [R12]

   // Input decode of the four drive modes
   always_comb
   begin
      sel_a = LEG_OFF; // [R1]
      sel_b = LEG_OFF;
      if (in_a && !in_b)
      begin
         sel_a = LEG_HIGH; // [R2]
         sel_b = LEG_LOW;
      end
      else if (!in_a && in_b)
      begin
         sel_a = LEG_LOW; // [R2]
         sel_b = LEG_HIGH;
      end
      else if (in_a && in_b)
      begin
         sel_a = LEG_LOW; // [R3]
         sel_b = LEG_LOW;
      end
   end

   always_comb
   begin
      next_state       = state;
      next_state.boot  = 1'b0;
      next_state.cmd_a = LEG_OFF;
      next_state.cmd_b = LEG_OFF;

      // Overcurrent filter counts cycles the indication persists
      if (over_i && state.pwr == PWR_RUN)
      begin
         if (state.oc_cnt != 8'hFF)
         begin
            next_state.oc_cnt = state.oc_cnt + 8'h1;
         end
      end
      else
      begin
         next_state.oc_cnt = 8'h0;
      end

      // Chop timer runs even under a fault so off-time stays fixed
      if (state.chop_cnt != 10'h0)
      begin
         next_state.chop_cnt = state.chop_cnt - 10'h1;
      end

      unique case (state.pwr)
         PWR_SLEEP:
         begin
            next_state.sleep_cnt = 16'h0;
            next_state.chop_cnt  = 10'h0;
            // Wake hold measured on the synchronised inputs [R6]
            if (any_in)
            begin
               next_state.wake_cnt = state.wake_cnt + 10'h1;
               if (state.wake_cnt >= 10'(`WAKE_HOLD_CYC - 1))
               begin
                  next_state.pwr      = PWR_WAKE;
                  next_state.wake_cnt = 10'h0;
               end
            end
            else
            begin
               next_state.wake_cnt = 10'h0;
            end
         end
         PWR_WAKE:
         begin
            // Bridge stays off until the wake time is over [R15] [R6]
            next_state.wake_cnt = state.wake_cnt + 10'h1;
            if (state.wake_cnt >= 10'(`WAKE_TIME_CYC - 1))
            begin
               next_state.pwr      = PWR_RUN;
               next_state.wake_cnt = 10'h0;
            end
         end
         PWR_RUN:
         begin
            // Any input high restarts the count [R14] [R4]
            if (any_in)
            begin
               next_state.sleep_cnt = 16'h0;
            end
            else if (state.sleep_cnt >= 16'(sleep_delay_cycles - 1))
            begin
               next_state.pwr       = PWR_SLEEP;
               next_state.sleep_cnt = 16'h0;
            end
            else
            begin
               next_state.sleep_cnt = state.sleep_cnt + 16'h1;
            end

            if (trip && state.chop_cnt == 10'h0)
            begin
               next_state.chop_cnt = 10'(`CHOP_OFF_CYC); // [R7]
            end

            if (state.oc_cnt >= 8'(`OC_FILTER_CYC))
            begin
               next_state.pwr       = PWR_RETRY; // [R11]
               next_state.retry_cnt = 16'h0;
               next_state.oc_cnt    = 8'h0;
            end
            else if (fault)
            begin
               next_state.cmd_a = LEG_OFF; // [R14] [R10] [R12]
               next_state.cmd_b = LEG_OFF;
            end
            else if (state.chop_cnt != 10'h0 || trip)
            begin
               next_state.cmd_a = LEG_LOW; // [R14] [R7]
               next_state.cmd_b = LEG_LOW;
            end
            else if (next_state.pwr == PWR_RUN)
            begin
               next_state.cmd_a = sel_a; // [R8]
               next_state.cmd_b = sel_b;
            end
         end
         PWR_RETRY:
         begin
            // Bridge off, then back to input control; repeats if still high
            if (state.retry_cnt >= 16'(retry_cycles - 1))
            begin
               next_state.pwr = PWR_RUN; // [R11]
            end
            else
            begin
               next_state.retry_cnt = state.retry_cnt + 16'h1;
            end
         end
         default:
         begin
            next_state.pwr = PWR_SLEEP;
         end
      endcase

      // First cycle after reset: inputs low means straight to sleep [R5]
      if (state.boot)
      begin
         next_state.pwr = any_in ? PWR_WAKE : PWR_SLEEP;
      end
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state.pwr       <= PWR_SLEEP;
         state.sleep_cnt <= 16'h0;
         state.retry_cnt <= 16'h0;
         state.wake_cnt  <= 10'h0;
         state.chop_cnt  <= 10'h0;
         state.oc_cnt    <= 8'h0;
         state.boot      <= 1'b1;
         state.cmd_a     <= LEG_OFF;
         state.cmd_b     <= LEG_OFF;
      end
      else
      begin
         state <= next_state;
      end
   end

   // ------------------------------------------------------------
   // Legs with shoot-through gap
   // ------------------------------------------------------------
   assign leg_a.cmd = state.cmd_a;
   assign leg_b.cmd = state.cmd_b;

   leg_driver drive_a (.clock(clock), .rst_n(rst_n), .bus(leg_a.leg));
   leg_driver drive_b (.clock(clock), .rst_n(rst_n), .bus(leg_b.leg));

   assign bridge_a_high = leg_a.gate_high;
   assign bridge_a_low  = leg_a.gate_low;
   assign bridge_b_high = leg_b.gate_high;
   assign bridge_b_low  = leg_b.gate_low;
   assign asleep        = (state.pwr == PWR_SLEEP);
endmodule

// [dv/pwm_controller_model.sv]
// Model of the controller that drives the two direction inputs
`timescale 1ns/1ps
module pwm_controller_model
(
   input  wire logic       clock,
   input  wire logic [1:0] mode,
   output logic            ctrl_input_a,
   output logic            ctrl_input_b
);
   // Pins start low, as the pulldowns would hold them
   initial
   begin
      ctrl_input_a = 1'b0;
      ctrl_input_b = 1'b0;
   end

   // Pins move just after an edge, like a timer-driven controller
   always @(posedge clock)
   begin
      ctrl_input_a <= mode[1];
      ctrl_input_b <= mode[0];
   end
endmodule

// [dv/h_bridge_drive_control_asserts.sv]
// Port checker of the H-bridge drive control
`timescale 1ns/1ps
module h_bridge_checker
#(
   parameter int unsigned sleep_delay_cycles = 200,
   parameter int unsigned retry_cycles       = 300
)
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic ctrl_input_a,
   input wire logic ctrl_input_b,
   input wire logic current_trip_level,
   input wire logic overcurrent_level,
   input wire logic supply_low_lockout,
   input wire logic thermal_cutoff,
   input wire logic bridge_a_high,
   input wire logic bridge_a_low,
   input wire logic bridge_b_high,
   input wire logic bridge_b_low,
   input wire logic asleep
);
   // ----------
   // Helpers
   // ----------
   localparam int SLEEP_LIM = sleep_delay_cycles + 520;
   logic [9:0] calm;
   logic [9:0] awake;
   logic [9:0] low_cnt;
   logic       any_in;
   logic       fault;
   logic [3:0] g;
   assign any_in = ctrl_input_a | ctrl_input_b;
   assign fault  = current_trip_level | overcurrent_level | supply_low_lockout | thermal_cutoff;
   assign g      = {bridge_a_high, bridge_a_low, bridge_b_high, bridge_b_low};

   // Saturate so a long run never wraps into a false window
   function automatic logic [9:0] sat(input logic [9:0] v);
      return (v == 10'h3FF) ? v : v + 10'h001;
   endfunction

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         calm    <= 10'h000;
         awake   <= 10'h000;
         low_cnt <= 10'h000;
      end
      else
      begin
         calm    <= (asleep || fault) ? 10'h000 : sat(calm);
         awake   <= asleep ? 10'h000 : sat(awake);
         low_cnt <= any_in ? 10'h000 : sat(low_cnt);
      end
   end

   // ----------
   // Properties
   // ----------
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);

   shoot_thru_a: assert property (!(bridge_a_high && bridge_a_low) && !(bridge_b_high && bridge_b_low))
      else $error("leg gates both on");
   gap_leg_a_a: assert property ($rose(bridge_a_low) |->
      !$past(bridge_a_high) && !$past(bridge_a_high, 2)) else $error("leg a gap short");
   gap_leg_b_a: assert property ($rose(bridge_b_high) |->
      !$past(bridge_b_low) && !$past(bridge_b_low, 2)) else $error("leg b gap short");
   coast_off_a: assert property ((!ctrl_input_a && !ctrl_input_b)[*8] ##2 (calm >= 600) |->
      g == 4'h0) else $error("coast not off");
   fwd_drive_a: assert property ((ctrl_input_a && !ctrl_input_b)[*8] ##2 (calm >= 600) |->
      g == 4'h9) else $error("forward wrong");
   brake_drive_a: assert property ((ctrl_input_a && ctrl_input_b)[*8] ##2 (calm >= 600) |->
      g == 4'h5) else $error("brake wrong");
   sleep_off_a: assert property (asleep |-> g == 4'h0) else $error("gate on in sleep");
   sleep_entry_a: assert property (low_cnt >= SLEEP_LIM |-> asleep) else $error("no sleep");
   wake_hold_a: assert property ($fell(asleep) |-> $past(any_in, 50)) else $error("early wake");
   wake_off_a: assert property (awake < 480 |-> g == 4'h0) else $error("gate on in wake");
   chop_low_a: assert property ($rose(current_trip_level) && calm >= 600 |->
      ##[4:12] (bridge_a_low && bridge_b_low)) else $error("no chop");
   supply_off_a: assert property (supply_low_lockout[*8] |-> g == 4'h0)
      else $error("gate on at supply low");
   hot_off_a: assert property (thermal_cutoff[*8] |-> g == 4'h0) else $error("gate on when hot");

   cover property ($rose(asleep));
   cover property ($fell(asleep));
   cover property ($rose(current_trip_level) && calm >= 600);
endmodule

bind h_bridge_drive_control h_bridge_checker
#(
   .sleep_delay_cycles(sleep_delay_cycles),
   .retry_cycles      (retry_cycles)
)
h_bridge_checker_inst
(
   .clock             (clock),
   .rst_n             (rst_n),
   .ctrl_input_a      (ctrl_input_a),
   .ctrl_input_b      (ctrl_input_b),
   .current_trip_level(current_trip_level),
   .overcurrent_level (overcurrent_level),
   .supply_low_lockout(supply_low_lockout),
   .thermal_cutoff    (thermal_cutoff),
   .bridge_a_high     (bridge_a_high),
   .bridge_a_low      (bridge_a_low),
   .bridge_b_high     (bridge_b_high),
   .bridge_b_low      (bridge_b_low),
   .asleep            (asleep)
);

// [dv/test_h_bridge_drive_control.sv]
// Self-checking bench of the H-bridge drive control
`timescale 1ns/1ps
module test_h_bridge_drive_control;
   logic       clock, rst_n, trip, oc, uv, hot, a, b, ah, al, bh, bl, asleep;
   logic [1:0] mode;
   logic [3:0] g;
   int         err_total, n_checks, cyc;
   assign g = {ah, al, bh, bl};

   // Short sleep and retry counts keep the run brief
   h_bridge_drive_control #(.sleep_delay_cycles(200), .retry_cycles(300)) h_bridge_drive_control_inst
   (
      .clock(clock), .rst_n(rst_n), .ctrl_input_a(a), .ctrl_input_b(b),
      .current_trip_level(trip), .overcurrent_level(oc), .supply_low_lockout(uv),
      .thermal_cutoff(hot), .bridge_a_high(ah), .bridge_a_low(al), .bridge_b_high(bh),
      .bridge_b_low(bl), .asleep(asleep)
   );
   pwm_controller_model pwm_controller_model_inst
   (
      .clock(clock), .mode(mode), .ctrl_input_a(a), .ctrl_input_b(b)
   );

   initial
   begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   // ----------
   // Helpers
   // ----------
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
   endtask

   // Samples at the falling edge, away from any update, then returns on a rising edge
   task automatic chk(input string nm, input logic [3:0] e, input logic [3:0] s);
      @(negedge clock);
      n_checks++;
      if (s !== e)
      begin
         err_total++;
         $display("ERROR %s expected %h seen %h", nm, e, s);
      end
      @(posedge clock);
   endtask

   task automatic conclude;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   always @(posedge clock)
   begin
      cyc <= cyc + 1;
      if (cyc == 12000)
      begin
         err_total++;
         conclude;
      end
   end

   // ----------
   // Scenarios
   // ----------
   task automatic t_wake;
      mode <= 2'h2;
      tick(40);
      chk("asleep", 4'h1, {3'h0, asleep});
      tick(30);
      chk("asleep", 4'h0, {3'h0, asleep});
      chk("wake gates", 4'h0, g);
      tick(530);
      chk("gates", 4'h9, g);
   endtask

   task automatic t_modes;
      logic [1:0] m [4] = '{2'h1, 2'h3, 2'h0, 2'h2};
      logic [3:0] e [4] = '{4'h6, 4'h5, 4'h0, 4'h9};
      for (int i = 0; i < 4; i++)
      begin
         mode <= m[i];
         tick(40);
         chk("mode gates", e[i], g);
      end
   endtask

   task automatic t_chop;
      trip <= 1'b1;
      tick(12);
      chk("chop", 4'h5, g);
      trip <= 1'b0;
      tick(200);
      chk("chop", 4'h5, g);
      tick(60);
      chk("restore", 4'h9, g);
   endtask

   task automatic t_faults;
      for (int i = 0; i < 2; i++)
      begin
         if (i == 0)
            uv <= 1'b1;
         else
            hot <= 1'b1;
         tick(10);
         chk("fault", 4'h0, g);
         uv <= 1'b0;
         hot <= 1'b0;
         tick(12);
         chk("resume", 4'h9, g);
      end
   endtask

   task automatic t_ocp;
      oc <= 1'b1;
      tick(45);
      chk("ocp", 4'h0, g);
      oc <= 1'b0;
      tick(100);
      chk("retry", 4'h0, g);
      tick(300);
      chk("retry end", 4'h9, g);
   endtask

   task automatic t_sleep;
      mode <= 2'h0;
      tick(150);
      chk("asleep", 4'h0, {3'h0, asleep});
      mode <= 2'h2;
      tick(10);
      mode <= 2'h0;
      tick(150);
      chk("asleep", 4'h0, {3'h0, asleep});
      tick(80);
      chk("asleep", 4'h1, {3'h0, asleep});
      tick(600);
      chk("sleep gates", 4'h0, g);
   endtask

   initial
   begin
      rst_n = 1'b0;
      mode = 2'h0;
      trip = 1'b0;
      oc = 1'b0;
      uv = 1'b0;
      hot = 1'b0;
      tick(3);
      rst_n <= 1'b1;
      tick(5);
      chk("boot", 4'h1, {3'h0, asleep});
      t_wake;
      t_modes;
      t_chop;
      t_faults;
      t_ocp;
      t_sleep;
      conclude;
   end
endmodule
